/* hdl/msil_defines.svh */
`ifndef MSIL_DEFINES_SVH
`define MSIL_DEFINES_SVH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define MSIL_IDX_ACT_THR 6'h24
`define MSIL_IDX_INACT_THR 6'h25
`define MSIL_IDX_INACT_TIME 6'h26
`define MSIL_IDX_INT_EN 6'h2e
`define MSIL_IDX_PIN_SEL 6'h2f
`define MSIL_IDX_CAUSE 6'h30
`define MSIL_IDX_FORMAT 6'h31
`define MSIL_IDX_X_LO 6'h32
`define MSIL_IDX_X_HI 6'h33
`define MSIL_IDX_Y_LO 6'h34
`define MSIL_IDX_Y_HI 6'h35
`define MSIL_IDX_Z_LO 6'h36
`define MSIL_IDX_Z_HI 6'h37
`define MSIL_IDX_BUF_CTL 6'h38
`define MSIL_IDX_BUF_STAT 6'h39

// ****************************************
// Source bit positions
// ****************************************
`define MSIL_BIT_NEW 7
`define MSIL_BIT_ACT 4
`define MSIL_BIT_INACT 3
`define MSIL_BIT_WMARK 1
`define MSIL_BIT_OVR 0
`define MSIL_SRC_MASK 8'h9b

// ****************************************
// Field positions and reset values
// ****************************************
`define MSIL_FMT_INVERT 5
`define MSIL_BUF_TRIG 5
`define MSIL_REG_RESET 8'h00
`define MSIL_CAUSE_RESET 8'h02

// ****************************************
// Buffer modes and sizes
// ****************************************
`define MSIL_MODE_BYPASS 2'h0
`define MSIL_MODE_FILL 2'h1
`define MSIL_MODE_STREAM 2'h2
`define MSIL_MODE_TRIGGER 2'h3
`define MSIL_BUF_DEPTH 6'h20
`define MSIL_THR_SHIFT 4

// ****************************************
// Timing
// ****************************************
`define MSIL_CLK_HZ 125000000
`define MSIL_INACT_UNIT_S 1

`endif

/* hdl/msil_pkg.sv */
package msil_pkg;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } msil_sample_t;

  typedef struct packed {
    logic [1:0] mode;
    logic trig_pin;
    logic [4:0] samples;
  } msil_buf_ctl_t;

endpackage

/* hdl/msil_top.sv */
// Functional notes
// - Two push-pull interrupt pins
// - Pins active high; format bit inverts both
// - All sources run together, may share pins
// - Source reaches pin only when enabled
// - Pin select register routes each source
// - Data flags clear by reading the Z high axis register
// - Reading cause clears activity and inactivity
// - New-sample flag follows unread sample availability
// - Activity set above activity threshold
// - Inactivity after quiet longer than limit
// - Watermark set when count equals samples field
// - Watermark clears when count drops below
// - Bypass overrun when unread sample overwritten
// - Other modes overrun when buffer fills
// - Overrun clears when buffer contents read
// - Four buffer modes from mode field
// - Bypass keeps buffer empty
// - Fill mode stops storing at 32
// - Watermark holds while count not below level
`timescale 1ns/1ns
`include "msil_defines.svh"

module msil_top
  import msil_pkg::*;
#(
  parameter int SEC_CYCLES = `MSIL_CLK_HZ * `MSIL_INACT_UNIT_S
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sample_valid,
  input wire msil_sample_t sample,
  output logic first_irq_pin,
  output logic second_irq_pin
);

  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0] activity_threshold_reg;
  logic [7:0] inactivity_threshold_reg;
  logic [7:0] inactivity_time_limit_reg;
  logic [7:0] interrupt_enable_reg;
  logic [7:0] interrupt_pin_select_reg;
  logic [7:0] output_format_control_reg;
  msil_buf_ctl_t buffer_control_reg;
  logic act_reg;
  logic inact_reg;
  logic ovr_reg;
  logic [31:0] prdata_reg;

  // ****************************************
  // Buffer and output sample state
  // ****************************************
  msil_sample_t ram [0:31];
  msil_sample_t out_reg;
  logic out_unread_reg;
  logic [4:0] wr_ptr_reg;
  logic [4:0] rd_ptr_reg;
  logic [5:0] count_reg;
  logic trig_hit_reg;
  logic quiet_run_reg;
  logic [31:0] tick_cnt_reg;
  logic [8:0] sec_cnt_reg;
  logic first_irq_reg;
  logic second_irq_reg;

  logic [5:0] idx;
  logic acc, wr_en, rd_en, mapped, consume, cause_read;
  logic [7:0] cause, live, rd_mux;
  logic bypass, fill_like, full, push, drop_old, load, trig_event;
  logic [5:0] count_next, trig_n;
  logic wmark, act_set, quiet, loud, sec_tick, inact_set, ovr_set;
  logic pin1_raw, pin2_raw;

  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction

  function automatic logic [15:0] scale(input logic [7:0] t);
    scale = {4'h0, t, 4'h0};
  endfunction

  // ****************************************
  // APB slave
  // ****************************************
  assign idx = paddr[7:2];
  assign acc = psel && penable;
  assign wr_en = acc && pwrite && mapped;
  assign rd_en = acc && !pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = prdata_reg;
  assign consume = rd_en && (idx == `MSIL_IDX_Z_HI);
  assign cause_read = rd_en && (idx == `MSIL_IDX_CAUSE);

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 8'h00;
    if (idx == `MSIL_IDX_ACT_THR)
      rd_mux = activity_threshold_reg;
    else if (idx == `MSIL_IDX_INACT_THR)
      rd_mux = inactivity_threshold_reg;
    else if (idx == `MSIL_IDX_INACT_TIME)
      rd_mux = inactivity_time_limit_reg;
    else if (idx == `MSIL_IDX_INT_EN)
      rd_mux = interrupt_enable_reg;
    else if (idx == `MSIL_IDX_PIN_SEL)
      rd_mux = interrupt_pin_select_reg;
    else if (idx == `MSIL_IDX_CAUSE)
      rd_mux = cause;
    else if (idx == `MSIL_IDX_FORMAT)
      rd_mux = output_format_control_reg;
    else if (idx == `MSIL_IDX_X_LO)
      rd_mux = out_reg.x[7:0];
    else if (idx == `MSIL_IDX_X_HI)
      rd_mux = out_reg.x[15:8];
    else if (idx == `MSIL_IDX_Y_LO)
      rd_mux = out_reg.y[7:0];
    else if (idx == `MSIL_IDX_Y_HI)
      rd_mux = out_reg.y[15:8];
    else if (idx == `MSIL_IDX_Z_LO)
      rd_mux = out_reg.z[7:0];
    else if (idx == `MSIL_IDX_Z_HI)
      rd_mux = out_reg.z[15:8];
    else if (idx == `MSIL_IDX_BUF_CTL)
      rd_mux = buffer_control_reg;
    else if (idx == `MSIL_IDX_BUF_STAT)
      rd_mux = {trig_hit_reg, 1'b0, count_reg};
    else
      mapped = 1'b0;
  end

  // Data captured in setup so the access phase needs no wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= 32'h0;
    else if (psel && !penable)
      prdata_reg <= {24'h0, rd_mux};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      activity_threshold_reg <= `MSIL_REG_RESET;
      inactivity_threshold_reg <= `MSIL_REG_RESET;
      inactivity_time_limit_reg <= `MSIL_REG_RESET;
      interrupt_enable_reg <= `MSIL_REG_RESET;
      interrupt_pin_select_reg <= `MSIL_REG_RESET;
      output_format_control_reg <= `MSIL_REG_RESET;
      buffer_control_reg <= msil_buf_ctl_t'(`MSIL_REG_RESET);
    end
    else if (wr_en)
    begin
      if (idx == `MSIL_IDX_ACT_THR)
        activity_threshold_reg <= pwdata[7:0];
      else if (idx == `MSIL_IDX_INACT_THR)
        inactivity_threshold_reg <= pwdata[7:0];
      else if (idx == `MSIL_IDX_INACT_TIME)
        inactivity_time_limit_reg <= pwdata[7:0];
      else if (idx == `MSIL_IDX_INT_EN)
        interrupt_enable_reg <= pwdata[7:0] & `MSIL_SRC_MASK;
      else if (idx == `MSIL_IDX_PIN_SEL)
        interrupt_pin_select_reg <= pwdata[7:0] & `MSIL_SRC_MASK;
      else if (idx == `MSIL_IDX_FORMAT)
        output_format_control_reg <= pwdata[7:0] & 8'hef;
      else if (idx == `MSIL_IDX_BUF_CTL)
        buffer_control_reg <= msil_buf_ctl_t'(pwdata[7:0]);
    end
  end

  // ****************************************
  // Sample buffer control
  // ****************************************
  assign bypass = buffer_control_reg.mode == `MSIL_MODE_BYPASS;
  assign fill_like = (buffer_control_reg.mode == `MSIL_MODE_FILL) ||
    ((buffer_control_reg.mode == `MSIL_MODE_TRIGGER) && trig_hit_reg);
  assign full = count_reg == `MSIL_BUF_DEPTH;
  assign trig_n = {1'b0, buffer_control_reg.samples};
  assign trig_event = (buffer_control_reg.mode == `MSIL_MODE_TRIGGER) &&
    !trig_hit_reg &&
    (buffer_control_reg.trig_pin ? pin2_raw : pin1_raw);

  // Trigger cycle only trims; a sample in that same cycle is dropped
  always_comb
  begin
    push = sample_valid && !bypass && !trig_event &&
      (!full || !fill_like);
    drop_old = push && full; // Stream keeps the latest 32
    load = !bypass && !trig_event && (count_reg != 6'h0) &&
      (!out_unread_reg || consume);
    count_next = count_reg + {5'h0, push} - {5'h0, drop_old} -
      {5'h0, load};
  end

  always_ff @(posedge pclk)
  begin
    if (push)
      ram[wr_ptr_reg] <= sample;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_reg <= 5'h0;
      rd_ptr_reg <= 5'h0;
      count_reg <= 6'h0;
      trig_hit_reg <= 1'b0;
    end
    else if (bypass)
    begin
      wr_ptr_reg <= 5'h0;
      rd_ptr_reg <= 5'h0;
      count_reg <= 6'h0;
      trig_hit_reg <= 1'b0;
    end
    else if (trig_event)
    begin
      trig_hit_reg <= 1'b1;
      if (count_reg > trig_n)
      begin
        rd_ptr_reg <= rd_ptr_reg + 5'(count_reg - trig_n);
        count_reg <= trig_n;
      end
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 5'h1;
      rd_ptr_reg <= rd_ptr_reg + {4'h0, drop_old} + {4'h0, load};
      count_reg <= count_next;
    end
  end

  // ****************************************
  // Axis output registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_reg <= '0;
      out_unread_reg <= 1'b0;
    end
    else if (bypass && sample_valid)
    begin
      out_reg <= sample;
      out_unread_reg <= 1'b1;
    end
    else if (load)
    begin
      out_reg <= ram[rd_ptr_reg + {4'h0, drop_old}];
      out_unread_reg <= 1'b1;
    end
    else if (consume)
      out_unread_reg <= 1'b0;
  end

  // ****************************************
  // Motion detection
  // ****************************************
  always_comb
  begin
    act_set = sample_valid &&
      ((mag(sample.x) > scale(activity_threshold_reg)) ||
       (mag(sample.y) > scale(activity_threshold_reg)) ||
       (mag(sample.z) > scale(activity_threshold_reg)));
    quiet = (mag(sample.x) < scale(inactivity_threshold_reg)) &&
      (mag(sample.y) < scale(inactivity_threshold_reg)) &&
      (mag(sample.z) < scale(inactivity_threshold_reg));
    loud = sample_valid && !quiet;
  end

  assign sec_tick = quiet_run_reg && (tick_cnt_reg == 32'(SEC_CYCLES - 1));
  // Set once on crossing so a cleared flag is not re-raised every cycle
  assign inact_set = sec_tick &&
    (sec_cnt_reg == {1'b0, inactivity_time_limit_reg});

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      quiet_run_reg <= 1'b0;
      tick_cnt_reg <= 32'h0;
      sec_cnt_reg <= 9'h0;
    end
    else if (loud)
    begin
      quiet_run_reg <= 1'b0;
      tick_cnt_reg <= 32'h0;
      sec_cnt_reg <= 9'h0;
    end
    else
    begin
      if (sample_valid)
        quiet_run_reg <= 1'b1;
      if (sec_tick)
        tick_cnt_reg <= 32'h0;
      else if (quiet_run_reg)
        tick_cnt_reg <= tick_cnt_reg + 32'h1;
      if (sec_tick && (sec_cnt_reg != 9'h1ff))
        sec_cnt_reg <= sec_cnt_reg + 9'h1;
    end
  end

  // ****************************************
  // Latched causes
  // ****************************************
  assign ovr_set = bypass ?
    (sample_valid && out_unread_reg && !consume) :
    ((push && (count_next == `MSIL_BUF_DEPTH)) || drop_old);
  assign wmark = count_reg >= trig_n;

  // Set wins over a clearing read in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      act_reg <= 1'b0;
      inact_reg <= 1'b0;
      ovr_reg <= 1'b0;
    end
    else
    begin
      if (act_set)
        act_reg <= 1'b1;
      else if (cause_read)
        act_reg <= 1'b0;
      if (inact_set)
        inact_reg <= 1'b1;
      else if (cause_read)
        inact_reg <= 1'b0;
      if (ovr_set)
        ovr_reg <= 1'b1;
      else if (consume || (bypass && !out_unread_reg))
        ovr_reg <= 1'b0;
    end
  end

  always_comb
  begin
    cause = 8'h00;
    cause[`MSIL_BIT_NEW] = out_unread_reg;
    cause[`MSIL_BIT_ACT] = act_reg;
    cause[`MSIL_BIT_INACT] = inact_reg;
    cause[`MSIL_BIT_WMARK] = wmark;
    cause[`MSIL_BIT_OVR] = ovr_reg;
  end

  // ****************************************
  // Interrupt pins
  // ****************************************
  assign live = cause & interrupt_enable_reg;
  assign pin1_raw = |(live & ~interrupt_pin_select_reg);
  assign pin2_raw = |(live & interrupt_pin_select_reg);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      first_irq_reg <= 1'b0;
      second_irq_reg <= 1'b0;
    end
    else
    begin
      first_irq_reg <= pin1_raw ^
        output_format_control_reg[`MSIL_FMT_INVERT];
      second_irq_reg <= pin2_raw ^
        output_format_control_reg[`MSIL_FMT_INVERT];
    end
  end

  // Push-pull: both levels always driven, no enable needed
  assign first_irq_pin = first_irq_reg;
  assign second_irq_pin = second_irq_reg;

endmodule

/* verif/msil_sva.sv */
`timescale 1ns/1ns
module msil_sva
  import msil_pkg::*;
#(
  parameter int SEC_CYCLES = 10
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sample_valid,
  input wire msil_sample_t sample,
  input wire logic first_irq_pin,
  input wire logic second_irq_pin
);
  // ****
  // Shadow of the routing registers
  // ****
  logic mapped;
  logic [7:0] en_sh;
  logic [7:0] sel_sh;
  logic [7:0] buf_sh;
  logic inv_sh;

  assign mapped = paddr[7:2] inside {6'h24, 6'h25, 6'h26, [6'h2e:6'h39]};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_sh <= 8'h00;
      sel_sh <= 8'h00;
      buf_sh <= 8'h00;
      inv_sh <= 1'b0;
    end
    else if (psel && penable && pready && pwrite)
    begin
      case (paddr[7:2])
        6'h2e: en_sh <= pwdata[7:0];
        6'h2f: sel_sh <= pwdata[7:0];
        6'h31: inv_sh <= pwdata[5];
        6'h38: buf_sh <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ****
  // Checks
  // ****
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (psel && penable && !mapped |-> pslverr)
    else $error("no error on unmapped index");
  a_err_mapped: assert property (psel && penable && mapped |-> !pslverr)
    else $error("error on mapped index");
  a_upper_zero: assert property (prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_pins_reset: assert property (
    $rose(presetn) |-> !first_irq_pin && !second_irq_pin)
    else $error("pins active after reset");
  a_first_idle: assert property (
    (en_sh & ~sel_sh) == 8'h00 |=> first_irq_pin == $past(inv_sh))
    else $error("first pin active with no source");
  a_second_idle: assert property (
    (en_sh & sel_sh) == 8'h00 |=> second_irq_pin == $past(inv_sh))
    else $error("second pin active with no source");
  a_wmark_level: assert property (
    en_sh[1] && !sel_sh[1] && buf_sh[4:0] == 5'h0 &&
    $past(buf_sh[4:0]) == 5'h0 |=> first_irq_pin != $past(inv_sh))
    else $error("watermark pin idle at level zero");
  a_new_sample: assert property (
    sample_valid && buf_sh[7:6] == 2'h0 && en_sh[7] && !sel_sh[7]
    |-> ##2 first_irq_pin != inv_sh)
    else $error("new sample not signalled");
endmodule

bind msil_top msil_sva #(.SEC_CYCLES(SEC_CYCLES)) u_msil_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
  .sample(sample), .first_irq_pin(first_irq_pin),
  .second_irq_pin(second_irq_pin)
);

/* verif/msil_host.sv */
`timescale 1ns/1ns
module msil_host
(
  input wire logic pclk,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  // ****
  // Host side of the register bus
  // ****
  logic hang = 1'b0;

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // Bounded wait, so a dead slave cannot stall the run
  task automatic xfer(input logic w, input logic [5:0] i,
    input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      hang = 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

/* verif/msil_top_test.sv */
`timescale 1ns/1ns
module msil_top_test
  import msil_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel;
  logic penable;
  logic pwrite;
  logic pready;
  logic pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic sample_valid = 1'b0;
  msil_sample_t sample = '0;
  logic first_irq_pin;
  logic second_irq_pin;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int n_mismatch = 0;
  int n_compared = 0;

  always #4 pclk = ~pclk;

  msil_top #(.SEC_CYCLES(10)) u_msil_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
    .sample(sample), .first_irq_pin(first_irq_pin),
    .second_irq_pin(second_irq_pin)
  );

  msil_host u_msil_host (
    .pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata)
  );

  // ****
  // Tasks
  // ****
  task automatic cmp(input logic [32:0] got, input logic [32:0] want);
    n_compared++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    u_msil_host.xfer(1'b1, i, d);
  endtask

  task automatic rd(input logic [5:0] i, input logic [7:0] d,
    input logic er = 1'b0);
    exp_q.push_back({er, 24'h0, d});
    u_msil_host.xfer(1'b0, i, 8'h00);
  endtask

  // Pins settle a few cycles after their cause
  task automatic pins(input logic [1:0] want);
    repeat (4) @(negedge pclk);
    cmp({31'h0, first_irq_pin, second_irq_pin}, {31'h0, want});
  endtask

  // Z stays zero so the last axis byte read is known
  task automatic send(input logic [15:0] x);
    @(posedge pclk);
    sample <= '{x, 16'($urandom % 16), 16'h0};
    sample_valid <= 1'b1;
    @(posedge pclk);
    sample_valid <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic tally_and_finish();
    if (u_msil_host.hang || exp_q.size() != 0)
      n_mismatch++;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****
  // Read checker
  // ****
  always @(posedge pclk)
  begin
    if (psel && penable && !pwrite)
    begin
      e = exp_q.size() ? exp_q.pop_front() : '1;
      cmp({pslverr, prdata}, e);
    end
  end

  // ****
  // Scenarios
  // ****
  initial
  begin
    void'($urandom(32'h8fb5dc0f));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(6'h30, 8'h02);
    rd(6'h2e, 8'h00);
    rd(6'h10, 8'h00, 1'b1);
    wr(6'h2e, 8'hff);
    rd(6'h2e, 8'h9b);
    pins(2'b10);
    wr(6'h2e, 8'h00);
    wr(6'h31, 8'hff);
    rd(6'h31, 8'hef);
    pins(2'b11);
    wr(6'h31, 8'h00);
    for (int m = 0; m < 4; m++)
    begin
      wr(6'h38, 8'(m << 6) | 8'h05);
      rd(6'h38, 8'(m << 6) | 8'h05);
    end
    $display("test 1 done");
    wr(6'h38, 8'h00);
    wr(6'h24, 8'h01);
    wr(6'h2f, 8'h10);
    wr(6'h2e, 8'h10);
    pins(2'b00);
    send(16'd100);
    pins(2'b01);
    rd(6'h30, 8'h92);
    rd(6'h30, 8'h82);
    pins(2'b00);
    wr(6'h31, 8'h20);
    pins(2'b11);
    $display("test 2 done");
    wr(6'h31, 8'h00);
    wr(6'h2f, 8'h00);
    wr(6'h2e, 8'h81);
    send(16'($urandom % 16));
    pins(2'b10);
    rd(6'h30, 8'h83);
    rd(6'h37, 8'h00);
    rd(6'h30, 8'h02);
    pins(2'b00);
    $display("test 3 done");
    wr(6'h2e, 8'h00);
    wr(6'h38, 8'h82);
    wr(6'h2e, 8'h02);
    repeat (3) send(16'($urandom % 16));
    pins(2'b10);
    rd(6'h30, 8'h82);
    rd(6'h37, 8'h00);
    pins(2'b00);
    rd(6'h30, 8'h80);
    $display("test 4 done");
    wr(6'h2e, 8'h00);
    wr(6'h38, 8'h00);
    rd(6'h37, 8'h00);
    wr(6'h38, 8'h5f);
    rd(6'h38, 8'h5f);
    wr(6'h2e, 8'h01);
    repeat (34) send(16'($urandom % 16));
    rd(6'h39, 8'h20);
    rd(6'h30, 8'h83);
    pins(2'b10);
    wr(6'h38, 8'h00);
    rd(6'h39, 8'h00);
    $display("test 5 done");
    wr(6'h2e, 8'h00);
    wr(6'h25, 8'h02);
    wr(6'h26, 8'h02);
    wr(6'h2f, 8'h08);
    rd(6'h37, 8'h00);
    wr(6'h2e, 8'h08);
    send(16'($urandom % 16));
    pins(2'b00);
    repeat (30) @(posedge pclk);
    pins(2'b01);
    rd(6'h30, 8'h8a);
    rd(6'h30, 8'h82);
    pins(2'b00);
    $display("test 6 done");
    @(posedge pclk);
    tally_and_finish();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
